// file: rtl/tiew_params.svh
`ifndef TIEW_PARAMS_SVH
`define TIEW_PARAMS_SVH

// counter, compare and capture width
`define TIEW_W          16

// start edge select encodings
`define TIEW_SES_STOP   2'h0
`define TIEW_SES_CMD    2'h1
`define TIEW_SES_RISE   2'h2
`define TIEW_SES_FALL   2'h3

// operating mode select encodings
`define TIEW_MODE_EVT   2'h0
`define TIEW_MODE_WIN   2'h1
`define TIEW_MODE_PWM   2'h2

// capture edge mode encodings
`define TIEW_CEM_DOUBLE 1'h0
`define TIEW_CEM_SINGLE 1'h1

// reset, reload and count step values
`define TIEW_CNT_RST    16'h0000
`define TIEW_CAP_RST    16'h0000
`define TIEW_CMP_RST    16'hffff
`define TIEW_BYTE_RST   8'h00
`define TIEW_CNT_HOLD   16'h0001
`define TIEW_CNT_STEP   16'h0001

`endif

// file: rtl/tiew_pkg.sv
`include "tiew_params.svh"

package tiew_pkg;

  typedef logic [`TIEW_W-1:0] tiew_word_t;

  typedef struct packed {
    logic       auto_capture_enable;
    logic [1:0] start_edge_select;
    logic       capture_edge_mode;
    logic [1:0] operating_mode_select;
  } tiew_ctrl_s;

  typedef enum logic [1:0] {
    TIEW_PW_IDLE,
    TIEW_PW_FIRST,
    TIEW_PW_SECOND,
    TIEW_PW_HOLD
  } tiew_pw_e;

  typedef struct packed {
    logic       pin_q;
    tiew_ctrl_s ctrl;
    tiew_pw_e   pw;
    tiew_word_t cnt;
    tiew_word_t cap;
    logic       irq;
  } tiew_state_s;

  typedef struct packed {
    logic [7:0] lo;
    logic [7:0] hi;
    logic       pending;
    tiew_word_t value;
  } tiew_cmp_s;

endpackage

// file: rtl/tiew_cmp_reg.sv
`include "tiew_params.svh"

module tiew_cmp_reg
  import tiew_pkg::*;
(
  // clock and reset
  input  wire logic       clk_sys,
  input  wire logic       rst_n,
  // byte writes
  input  wire logic       wr_lo,
  input  wire logic       wr_hi,
  input  wire logic [7:0] wdata,
  // counter source clock
  input  wire logic       src_tick,
  // active value
  output tiew_word_t      value
);

  tiew_cmp_s st;
  tiew_cmp_s next_st;

  // low byte alone only stages; high byte arms the load at next source tick
  always_comb begin
    next_st = st;
    if (st.pending && src_tick) begin
      next_st.value   = {st.hi, st.lo};
      next_st.pending = 1'b0;
    end
    if (wr_lo) begin
      next_st.lo = wdata;
    end
    if (wr_hi) begin
      next_st.hi      = wdata;
      next_st.pending = 1'b1;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      st <= '{lo: `TIEW_BYTE_RST, hi: `TIEW_BYTE_RST, pending: 1'b0, value: `TIEW_CMP_RST};
    end else begin
      st <= next_st;
    end
  end

  assign value = st.value;

endmodule

// file: rtl/tiew_timer.sv
// Summary of operation
// - event mode counts on the selected pin edge, rising or falling
// - event and window modes: counter equal compare raises interrupt and clears
// - after clearing, event mode keeps counting on later selected edges
// - event mode checks the match only at the opposite pin edge
// - auto capture copies the counter into capture on every source tick while the timer runs in event or window mode
// - window mode counts source ticks while the window gate is open
// - window polarity selects counting while pin high or while pin low
// - pulse mode starts on the trigger edge then counts source ticks
// - capture edge mode one means single edge, zero means double edge
// - single edge: capture, interrupt, set counter to one at opposite edge, wait trigger
// - double edge: capture at opposite edge, again at trigger and clear
// - single edge holds counter at one until the next trigger edge
// - mode field: 00 event, 01 window, 10 pulse measurement
// - stop power mode entry clears start edge select to stop
// - auto capture acts only in event and window modes
`include "tiew_params.svh"

module tiew_timer
  import tiew_pkg::*;
(
  // clock and reset
  input  wire logic       clk_sys,
  input  wire logic       rst_n,
  // external input and source clock
  input  wire logic       timer_input_pin,
  input  wire logic       src_tick,
  input  wire logic       stop_mode_entry,
  // control register
  input  wire logic       ctrl_wr,
  input  tiew_ctrl_s      ctrl_wdata,
  output tiew_ctrl_s      timer_control_register,
  // compare register byte writes
  input  wire logic       cmp_wr_lo,
  input  wire logic       cmp_wr_hi,
  input  wire logic [7:0] cmp_wdata,
  output tiew_word_t      compare_a_register,
  // capture and status
  output tiew_word_t      capture_b_register,
  output tiew_word_t      counter_value,
  output logic            timer_match_interrupt
);

  tiew_state_s st;
  tiew_state_s next_st;
  tiew_word_t  cmp;
  logic        rise;
  logic        fall;
  logic        running;
  logic        trig;
  logic        opp;
  logic        gate;
  logic        cmp_hit;
  logic        single;

  ////////////////////////////////////////////////////////////////////////////////
  tiew_cmp_reg u_cmp (
    .clk_sys  (clk_sys),
    .rst_n    (rst_n),
    .wr_lo    (cmp_wr_lo),
    .wr_hi    (cmp_wr_hi),
    .wdata    (cmp_wdata),
    .src_tick (src_tick),
    .value    (cmp)
  );

  ////////////////////////////////////////////////////////////////////////////////
  assign rise    = timer_input_pin & ~st.pin_q;
  assign fall    = ~timer_input_pin & st.pin_q;
  assign running = (st.ctrl.start_edge_select == `TIEW_SES_RISE) ||
                   (st.ctrl.start_edge_select == `TIEW_SES_FALL);
  assign trig    = (st.ctrl.start_edge_select == `TIEW_SES_RISE) ? rise : fall;
  assign opp     = (st.ctrl.start_edge_select == `TIEW_SES_RISE) ? fall : rise;
  assign gate    = (st.ctrl.start_edge_select == `TIEW_SES_RISE) ?
                   timer_input_pin : ~timer_input_pin;
  assign cmp_hit = (st.cnt == cmp);
  assign single  = (st.ctrl.capture_edge_mode == `TIEW_CEM_SINGLE);

  always_comb begin
    next_st       = st;
    next_st.pin_q = timer_input_pin;
    next_st.irq   = 1'b0;
    if (ctrl_wr) begin
      next_st.ctrl = ctrl_wdata;
    end
    if (stop_mode_entry) begin
      next_st.ctrl.start_edge_select = `TIEW_SES_STOP;
    end
    if (!running) begin
      next_st.cnt = `TIEW_CNT_RST;
      next_st.pw  = TIEW_PW_IDLE;
    end else begin
      unique case (st.ctrl.operating_mode_select)
        `TIEW_MODE_EVT: begin
          if (trig) begin
            next_st.cnt = st.cnt + `TIEW_CNT_STEP;
          end else if (opp && cmp_hit) begin
            next_st.irq = 1'b1;
            next_st.cnt = `TIEW_CNT_RST;
          end
        end
        `TIEW_MODE_WIN: begin
          if (src_tick && gate) begin
            if (cmp_hit) begin
              next_st.irq = 1'b1;
              next_st.cnt = `TIEW_CNT_RST;
            end else begin
              next_st.cnt = st.cnt + `TIEW_CNT_STEP;
            end
          end
        end
        `TIEW_MODE_PWM: begin
          unique case (st.pw)
            TIEW_PW_IDLE: begin
              if (trig) begin
                next_st.pw  = TIEW_PW_FIRST;
                next_st.cnt = `TIEW_CNT_RST;
              end
            end
            TIEW_PW_FIRST: begin
              if (opp) begin
                next_st.cap = st.cnt;
                next_st.irq = 1'b1;
                if (single) begin
                  next_st.cnt = `TIEW_CNT_HOLD;
                  next_st.pw  = TIEW_PW_HOLD;
                end else begin
                  next_st.pw  = TIEW_PW_SECOND;
                  if (src_tick) begin
                    next_st.cnt = st.cnt + `TIEW_CNT_STEP;
                  end
                end
              end else if (src_tick) begin
                next_st.cnt = st.cnt + `TIEW_CNT_STEP;
              end
            end
            TIEW_PW_SECOND: begin
              if (trig) begin
                next_st.cap = st.cnt;
                next_st.irq = 1'b1;
                next_st.cnt = `TIEW_CNT_RST;
                next_st.pw  = TIEW_PW_FIRST;
              end else if (src_tick) begin
                next_st.cnt = st.cnt + `TIEW_CNT_STEP;
              end
            end
            TIEW_PW_HOLD: begin
              if (trig) begin
                next_st.pw = TIEW_PW_FIRST;
              end
            end
          endcase
        end
        default: begin
          next_st.cnt = st.cnt;
        end
      endcase
      if (st.ctrl.auto_capture_enable && src_tick &&
          ((st.ctrl.operating_mode_select == `TIEW_MODE_EVT) ||
           (st.ctrl.operating_mode_select == `TIEW_MODE_WIN))) begin
        next_st.cap = st.cnt;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      st <= '{pin_q: 1'b0,
              ctrl:  '{auto_capture_enable: 1'b0, start_edge_select: `TIEW_SES_STOP,
                       capture_edge_mode: `TIEW_CEM_DOUBLE,
                       operating_mode_select: `TIEW_MODE_EVT},
              pw:    TIEW_PW_IDLE,
              cnt:   `TIEW_CNT_RST,
              cap:   `TIEW_CAP_RST,
              irq:   1'b0};
    end else begin
      st <= next_st;
    end
  end

  assign timer_control_register = st.ctrl;
  assign compare_a_register     = cmp;
  assign capture_b_register     = st.cap;
  assign counter_value          = st.cnt;
  assign timer_match_interrupt  = st.irq;

  ////////////////////////////////////////////////////////////////////////////////
  logic evt_on;
  logic win_on;
  logic pwm_on;
  assign evt_on = running && (st.ctrl.operating_mode_select == `TIEW_MODE_EVT);
  assign win_on = running && (st.ctrl.operating_mode_select == `TIEW_MODE_WIN);
  assign pwm_on = running && (st.ctrl.operating_mode_select == `TIEW_MODE_PWM);

  property p_evt_inc;
    @(posedge clk_sys) disable iff (!rst_n)
    (evt_on && trig) |=> (st.cnt == $past(st.cnt) + `TIEW_CNT_STEP) && !st.irq;
  endproperty
  a_evt_inc: assert property (p_evt_inc) else $error("event count step wrong");

  property p_evt_match;
    @(posedge clk_sys) disable iff (!rst_n)
    (evt_on && opp && cmp_hit) |=> st.irq && (st.cnt == `TIEW_CNT_RST);
  endproperty
  a_evt_match: assert property (p_evt_match) else $error("event match missed");

  property p_evt_no_early;
    @(posedge clk_sys) disable iff (!rst_n)
    (evt_on && !opp) |=> !st.irq;
  endproperty
  a_evt_no_early: assert property (p_evt_no_early) else $error("event irq off edge");

  property p_win_gate;
    @(posedge clk_sys) disable iff (!rst_n)
    (win_on && !(src_tick && gate)) |=> (st.cnt == $past(st.cnt)) && !st.irq;
  endproperty
  a_win_gate: assert property (p_win_gate) else $error("window counted while closed");

  property p_win_match;
    @(posedge clk_sys) disable iff (!rst_n)
    (win_on && src_tick && gate && cmp_hit) |=> st.irq && (st.cnt == `TIEW_CNT_RST);
  endproperty
  a_win_match: assert property (p_win_match) else $error("window match missed");

  property p_acap;
    @(posedge clk_sys) disable iff (!rst_n)
    ((evt_on || win_on) && st.ctrl.auto_capture_enable && src_tick)
      |=> st.cap == $past(st.cnt);
  endproperty
  a_acap: assert property (p_acap) else $error("auto capture missed");

  property p_single;
    @(posedge clk_sys) disable iff (!rst_n)
    (pwm_on && st.pw == TIEW_PW_FIRST && opp && single)
      |=> st.irq && (st.cap == $past(st.cnt)) && (st.cnt == `TIEW_CNT_HOLD);
  endproperty
  a_single: assert property (p_single) else $error("single edge capture wrong");

  property p_hold;
    @(posedge clk_sys) disable iff (!rst_n)
    (pwm_on && st.pw == TIEW_PW_HOLD && !trig) |=> st.cnt == `TIEW_CNT_HOLD;
  endproperty
  a_hold: assert property (p_hold) else $error("hold value lost");

  property p_double;
    @(posedge clk_sys) disable iff (!rst_n)
    (pwm_on && st.pw == TIEW_PW_SECOND && trig)
      |=> st.irq && (st.cap == $past(st.cnt)) && (st.cnt == `TIEW_CNT_RST);
  endproperty
  a_double: assert property (p_double) else $error("double edge period wrong");

  property p_stop;
    @(posedge clk_sys) disable iff (!rst_n)
    stop_mode_entry |=> (st.ctrl.start_edge_select == `TIEW_SES_STOP) ##1
                        (st.cnt == `TIEW_CNT_RST);
  endproperty
  a_stop: assert property (p_stop) else $error("stop entry did not halt");

  c_evt_match: cover property (@(posedge clk_sys) disable iff (!rst_n) evt_on && st.irq);
  c_win_match: cover property (@(posedge clk_sys) disable iff (!rst_n) win_on && st.irq);
  c_single:    cover property (@(posedge clk_sys) disable iff (!rst_n)
                               pwm_on && single && st.pw == TIEW_PW_HOLD ##1 trig);
  c_double:    cover property (@(posedge clk_sys) disable iff (!rst_n)
                               pwm_on && st.pw == TIEW_PW_SECOND && trig);

endmodule

// file: dv/tiew_pulse_src.sv
module tiew_pulse_src
  import tiew_pkg::*;
(
  // clock
  input  wire logic       clk_sys,
  // request
  input  wire logic       go,
  input  wire logic       idle_lvl,
  input  wire logic [7:0] act_cyc,
  input  wire logic [7:0] rest_cyc,
  input  wire logic [3:0] npulse,
  // pin side
  output logic            timer_input_pin,
  output logic            busy
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    timer_input_pin = 1'b0;
    busy = 1'b0;
    forever begin
      @(posedge clk_sys);
      if (go) begin
        busy <= 1'b1;
        repeat (npulse) begin
          timer_input_pin <= ~idle_lvl;
          repeat ((act_cyc < 8'h02) ? 8'h02 : act_cyc) @(posedge clk_sys);
          timer_input_pin <= idle_lvl;
          repeat ((rest_cyc < 8'h02) ? 8'h02 : rest_cyc) @(posedge clk_sys);
        end
        busy <= 1'b0;
      end else begin
        timer_input_pin <= idle_lvl;
      end
    end
  end
endmodule

// file: dv/timer_input_event_window_pulse_modes_test.sv
`include "tiew_params.svh"
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin fail_count++; \
  $display("ERROR t=%0t got=%h exp=%h", $time, (g), (e)); end end

module timer_input_event_window_pulse_modes_test
  import tiew_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic       clk_sys, rst_n, src_tick, stop_mode_entry, ctrl_wr, cmp_wr_lo, cmp_wr_hi;
  logic       timer_input_pin, timer_match_interrupt, busy, go, idle_lvl, gate, win_on;
  logic [7:0] cmp_wdata, act_cyc, rest_cyc;
  logic [3:0] npulse;
  tiew_ctrl_s ctrl_wdata, timer_control_register;
  tiew_word_t compare_a_register, capture_b_register, counter_value;
  tiew_word_t caps[$];
  int         fail_count, cmp_count, cyc, irq_cnt, exp_ticks;

  tiew_timer dut_u (.clk_sys(clk_sys), .rst_n(rst_n), .timer_input_pin(timer_input_pin),
    .src_tick(src_tick), .stop_mode_entry(stop_mode_entry), .ctrl_wr(ctrl_wr),
    .ctrl_wdata(ctrl_wdata), .timer_control_register(timer_control_register),
    .cmp_wr_lo(cmp_wr_lo), .cmp_wr_hi(cmp_wr_hi), .cmp_wdata(cmp_wdata),
    .compare_a_register(compare_a_register), .capture_b_register(capture_b_register),
    .counter_value(counter_value), .timer_match_interrupt(timer_match_interrupt));

  tiew_pulse_src src_u (.clk_sys(clk_sys), .go(go), .idle_lvl(idle_lvl), .act_cyc(act_cyc),
    .rest_cyc(rest_cyc), .npulse(npulse), .timer_input_pin(timer_input_pin), .busy(busy));

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end

  // source tick every fourth cycle, irq and window monitors, hang cutoff
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    src_tick <= (cyc % 4 == 3);
    if (src_tick === 1'b1 && timer_input_pin === gate && win_on) exp_ticks++;
    if (timer_match_interrupt === 1'b1) begin
      irq_cnt++;
      caps.push_back(capture_b_register);
    end
    if (cyc == 20000) begin
      fail_count++;
      end_sim();
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic set_ctrl(input logic a, input logic [1:0] s, input logic c, input logic [1:0] m);
    @(posedge clk_sys);
    ctrl_wr <= 1'b1;
    ctrl_wdata <= '{a, s, c, m};
    @(posedge clk_sys);
    ctrl_wr <= 1'b0;
    @(posedge clk_sys);
    #1;
    `CHK(timer_control_register, tiew_ctrl_s'({a, s, c, m}))
  endtask

  task automatic set_cmp(input tiew_word_t v, input bit hi_too, input tiew_word_t exp);
    @(posedge clk_sys);
    cmp_wr_lo <= 1'b1;
    cmp_wdata <= v[7:0];
    @(posedge clk_sys);
    cmp_wr_lo <= 1'b0;
    cmp_wr_hi <= hi_too;
    cmp_wdata <= v[15:8];
    @(posedge clk_sys);
    cmp_wr_hi <= 1'b0;
    do @(posedge clk_sys); while (src_tick !== 1'b1);
    #1;
    `CHK(compare_a_register, exp)
  endtask

  task automatic start_pulses(input int n, input int a, input int r);
    @(posedge clk_sys);
    npulse <= 4'(n);
    act_cyc <= 8'(a);
    rest_cyc <= 8'(r);
    go <= 1'b1;
    @(posedge clk_sys);
    go <= 1'b0;
    repeat (2) @(posedge clk_sys);
  endtask

  task automatic wait_idle();
    while (busy === 1'b1) @(posedge clk_sys);
    repeat (4) @(posedge clk_sys);
    #1;
  endtask

  task automatic pulses(input int n, input int a, input int r);
    start_pulses(n, a, r);
    wait_idle();
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    {rst_n, stop_mode_entry, ctrl_wr, cmp_wr_lo, cmp_wr_hi, go, idle_lvl} = '0;
    {gate, win_on, cmp_wdata, act_cyc, rest_cyc, npulse, ctrl_wdata} = '0;
    {fail_count, cmp_count, irq_cnt, exp_ticks} = '0;
    repeat (5) @(posedge clk_sys);
    rst_n <= 1'b1;
    #1;
    `CHK(timer_control_register, tiew_ctrl_s'(6'h00))
    `CHK(compare_a_register, `TIEW_CMP_RST)
    `CHK(capture_b_register, `TIEW_CAP_RST)
    `CHK(counter_value, `TIEW_CNT_RST)
    set_cmp(16'h0002, 1'b1, 16'h0002);
    set_cmp(16'h0055, 1'b0, 16'h0002);
    set_cmp(16'h0002, 1'b1, 16'h0002);
    // event counting on both edge selections
    for (int i = 0; i < 2; i++) begin
      idle_lvl <= (i == 1);
      set_ctrl(1'b0, `TIEW_SES_STOP, 1'b0, `TIEW_MODE_EVT);
      irq_cnt = 0;
      set_ctrl(1'b0, i ? `TIEW_SES_FALL : `TIEW_SES_RISE, 1'b0, `TIEW_MODE_EVT);
      pulses(1, 4, 4);
      `CHK(counter_value, 16'h0001)
      start_pulses(1, 20, 4);
      repeat (6) @(posedge clk_sys);
      #1;
      `CHK(counter_value, 16'h0002)
      `CHK(irq_cnt, 0)
      wait_idle();
      `CHK(irq_cnt, 1)
      `CHK(counter_value, 16'h0000)
      pulses(3, 3, 5);
      `CHK(counter_value, 16'h0001)
      `CHK(irq_cnt, 2)
    end
    // auto capture in event mode, read several source ticks later while still running
    set_cmp(16'h0010, 1'b1, 16'h0010);
    set_ctrl(1'b1, `TIEW_SES_FALL, 1'b0, `TIEW_MODE_EVT);
    pulses(2, 4, 4);
    repeat (12) @(posedge clk_sys);
    #1;
    `CHK(capture_b_register, 16'h0003)
    // stop entry beats a control write
    @(posedge clk_sys);
    stop_mode_entry <= 1'b1;
    ctrl_wr <= 1'b1;
    ctrl_wdata <= '{1'b0, `TIEW_SES_RISE, 1'b0, `TIEW_MODE_EVT};
    @(posedge clk_sys);
    stop_mode_entry <= 1'b0;
    ctrl_wr <= 1'b0;
    repeat (2) @(posedge clk_sys);
    #1;
    `CHK(timer_control_register.start_edge_select, `TIEW_SES_STOP)
    `CHK(counter_value, 16'h0000)
    // undefined mode code holds the counter and takes no auto capture
    set_ctrl(1'b1, `TIEW_SES_RISE, 1'b0, 2'h3);
    pulses(1, 4, 4);
    `CHK(counter_value, 16'h0000)
    `CHK(capture_b_register, 16'h0003)
    // window mode, both polarities
    set_cmp(16'h0003, 1'b1, 16'h0003);
    for (int i = 0; i < 2; i++) begin
      idle_lvl <= (i == 1);
      gate <= (i == 0);
      set_ctrl(1'b0, `TIEW_SES_STOP, 1'b0, `TIEW_MODE_WIN);
      {irq_cnt, exp_ticks} = '0;
      set_ctrl(1'b0, i ? `TIEW_SES_FALL : `TIEW_SES_RISE, 1'b0, `TIEW_MODE_WIN);
      win_on = 1'b1;
      pulses(2, 50, 30);
      win_on = 1'b0;
      `CHK(counter_value, 16'(exp_ticks % 4))
      `CHK(irq_cnt, exp_ticks / 4)
    end
    // pulse measurement, single then double edge
    for (int i = 0; i < 2; i++) begin
      idle_lvl <= 1'b0;
      set_ctrl(1'b0, `TIEW_SES_STOP, 1'b0, `TIEW_MODE_PWM);
      set_ctrl(1'b1, `TIEW_SES_RISE, (i == 0), `TIEW_MODE_PWM);
      repeat (8) @(posedge clk_sys);
      #1;
      `CHK(counter_value, 16'h0000)
      caps.delete();
      irq_cnt = 0;
      pulses(3, 40, 40);
      if (i == 0) begin
        `CHK(irq_cnt, 3)
        `CHK(caps[1], caps[0] + 16'h0001)
        `CHK(caps[2], caps[1])
        `CHK(counter_value, 16'h0001)
        `CHK(capture_b_register, caps[2])
      end else begin
        `CHK(irq_cnt, 5)
        `CHK(caps[4], caps[2])
        `CHK(caps[3], caps[2] + 16'h000a)
      end
    end
    end_sim();
  end
endmodule
